// file: core/pcs_pkg.sv
// pulse clean output sequencer: shared constants, register map and types
// assumes a 100 MHz clock and a classic wishbone master with 32-bit data
package pcs_pkg;
	localparam int CLK_NS      = 10;
	localparam int MS_NS       = 1000000;
	localparam int MS_CYCLES   = MS_NS / CLK_NS;
	localparam int OFF_UNIT_MS = 100;
	localparam int NOUT_MAX    = 10;
	localparam int ADR_W       = 8;

	localparam logic [ADR_W-1:0] CTRL_OFS   = 8'h00;
	localparam logic [ADR_W-1:0] NOUT_OFS   = 8'h04;
	localparam logic [ADR_W-1:0] ON_OFS     = 8'h08;
	localparam logic [ADR_W-1:0] OFF_OFS    = 8'h0c;
	localparam logic [ADR_W-1:0] STATUS_OFS = 8'h10;

	localparam int CTRL_MODE_BIT = 0;
	localparam int ST_PHASE_BIT  = 4;
	localparam int ST_PAUSE_BIT  = 5;
	localparam int ST_OUT_LSB    = 8;

	localparam logic [3:0]  NOUT_MIN  = 4'h2;
	localparam logic [3:0]  NOUT_TOP  = 4'ha;
	localparam logic [7:0]  ON_MIN    = 8'h14;
	localparam logic [7:0]  ON_TOP    = 8'hc8;
	localparam logic [9:0]  OFF_MIN   = 10'h00f;
	localparam logic [9:0]  OFF_TOP   = 10'h258;
	localparam logic [3:0]  NOUT_RST  = 4'ha;
	localparam logic [7:0]  ON_RST    = 8'h64;
	localparam logic [9:0]  OFF_RST   = 10'h064;

	typedef enum logic [0:0] {
		PH_OFF = 1'b0,
		PH_ON  = 1'b1
	} pcs_phase_t;

	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [3:0]       sel;
		logic [31:0]      dat;
	} pcs_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pcs_wb_rsp_t;

	typedef struct packed {
		pcs_phase_t    phase;
		logic [3:0]    idx;
		logic [15:0]   ms_cnt;
		logic [16:0]   pre_cnt;
		logic          mode;
		logic [3:0]    nout;
		logic [7:0]    on_ms;
		logic [9:0]    off_ds;
		logic [9:0]    sol;
		pcs_wb_rsp_t   rsp;
	} pcs_state_t;
endpackage

// file: core/pcs_seq.sv
// pulse clean output sequencer: fires solenoid outputs one at a time
// assumes the pressure switch input is already debounced and synchronous to clk_i
// assumes a classic wishbone master; a new setting acts on the running interval
// assumes TICK_CYCLES clocks make one millisecond
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module pcs_seq
	import pcs_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// register bus
	input  wire pcs_wb_req_t  wb_i,
	output pcs_wb_rsp_t       wb_o,
	// field side
	input  wire logic         press_closed_i,
	output logic [NOUT_MAX-1:0] sol_o,
	output logic [NOUT_MAX-1:0] led_o
);
	pcs_state_t s_reg;
	pcs_state_t s_next;

	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
			input logic [31:0] wd, input logic [3:0] sel);
		logic [15:0] r;
		r = old_v;
		if (sel[0]) begin
			r[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	logic        tick;
	logic        run_ok;
	logic [15:0] off_ms;
	logic [15:0] on_lim;
	logic [15:0] wv;
	logic        acc;
	logic [31:0] rd;
	logic [31:0] status_w;

	// register write strobes, true only on the edge that sees ack high, so
	// a write lands once per ack, and again every second clock while the master holds the request
	logic        wr_any;
	logic        wr_ctrl;
	logic        wr_nout;
	logic        wr_on;
	logic        wr_off;

	// sequencer helpers, all worked out from the registered state
	logic                off_done;
	logic                on_done;
	logic                last_out;
	logic [3:0]          fire_idx;
	logic [3:0]          idx_after;
	logic [15:0]         ms_inc;
	logic [16:0]         pre_inc;
	logic [NOUT_MAX-1:0] fire_vec;
	logic [NOUT_MAX-1:0] en_vec;

	assign wr_any  = wb_i.cyc & wb_i.stb & wb_i.we & s_reg.rsp.ack;
	assign wr_ctrl = wr_any & (wb_i.adr == CTRL_OFS);
	assign wr_nout = wr_any & (wb_i.adr == NOUT_OFS);
	assign wr_on   = wr_any & (wb_i.adr == ON_OFS);
	assign wr_off  = wr_any & (wb_i.adr == OFF_OFS);

	// a setting lowered below the waiting index must not fire a skipped output
	assign fire_idx  = (s_reg.idx >= s_reg.nout) ? 4'h0 : s_reg.idx;

	// wrap after the highest selected output; this also catches a setting
	// lowered while a pulse runs
	assign last_out  = (s_reg.idx >= s_reg.nout - 4'h1);
	assign idx_after = last_out ? 4'h0 : s_reg.idx + 4'h1;

	assign ms_inc  = s_reg.ms_cnt + 16'h0001;
	assign pre_inc = s_reg.pre_cnt + 17'h00001;

	// one decoder bit per output; only the waiting index can be high, and
	// only outputs up to the setting are enabled, so two valves never open
	genvar g;
	generate
		for (g = 0; g < NOUT_MAX; g = g + 1) begin : g_dec
			assign fire_vec[g] = (fire_idx == 4'(g));
			assign en_vec[g]   = (4'(g) < s_reg.nout);
		end
	endgenerate

	// status word: waiting or active index, phase, pause flag and the drives;
	// the pause flag is rebuilt here so it does not loop through the main block
	always_comb begin
		status_w                         = 32'h0000_0000;
		status_w[3:0]                    = s_reg.idx;
		status_w[ST_PHASE_BIT]           = s_reg.phase;
		status_w[ST_PAUSE_BIT]           = s_reg.mode & ~press_closed_i;
		status_w[ST_OUT_LSB +: NOUT_MAX] = s_reg.sol;
	end

	always_comb begin
		tick     = (s_reg.pre_cnt == 17'(TICK_CYCLES - 1));
		// continuous mode ignores the switch entirely
		run_ok   = ~s_reg.mode | press_closed_i;
		// widened before the product: 600 tenths times 100 needs 16 bits
		off_ms   = 16'(s_reg.off_ds) * 16'(OFF_UNIT_MS);
		on_lim   = {8'h00, s_reg.on_ms};
		off_done = (ms_inc >= off_ms);
		on_done  = (ms_inc >= on_lim);
		acc      = wb_i.cyc & wb_i.stb;
		wv       = 16'h0000;
		rd       = 32'h0000_0000;

		case (wb_i.adr)
			CTRL_OFS: begin
				rd[CTRL_MODE_BIT] = s_reg.mode;
			end

			NOUT_OFS: begin
				rd[3:0] = s_reg.nout;
			end

			ON_OFS: begin
				rd[7:0] = s_reg.on_ms;
			end

			OFF_OFS: begin
				rd[9:0] = s_reg.off_ds;
			end

			STATUS_OFS: begin
				rd = status_w;
			end

			default: begin
				rd = 32'h0000_0000;
			end
		endcase

		s_next = s_reg;

		// bus: ack one cycle after the request, write lands at the ack edge
		s_next.rsp.ack = acc & ~s_reg.rsp.ack;
		if (acc & ~s_reg.rsp.ack) begin
			s_next.rsp.dat = rd;
		end

		// out-of-range settings are clamped, never stored raw, so a stray write
		// cannot leave the sequencer on a zero or runaway interval
		if (wr_ctrl) begin
			if (wb_i.sel[0]) begin
				s_next.mode = wb_i.dat[CTRL_MODE_BIT];
			end
		end

		if (wr_nout) begin
			wv = lane_merge({12'h000, s_reg.nout}, wb_i.dat, wb_i.sel);
			if (wv < {12'h000, NOUT_MIN}) begin
				s_next.nout = NOUT_MIN;
			end else if (wv > {12'h000, NOUT_TOP}) begin
				s_next.nout = NOUT_TOP;
			end else begin
				s_next.nout = wv[3:0];
			end
		end

		if (wr_on) begin
			wv = lane_merge({8'h00, s_reg.on_ms}, wb_i.dat, wb_i.sel);
			if (wv < {8'h00, ON_MIN}) begin
				s_next.on_ms = ON_MIN;
			end else if (wv > {8'h00, ON_TOP}) begin
				s_next.on_ms = ON_TOP;
			end else begin
				s_next.on_ms = wv[7:0];
			end
		end

		if (wr_off) begin
			wv = lane_merge({6'h00, s_reg.off_ds}, wb_i.dat, wb_i.sel);
			if (wv < {6'h00, OFF_MIN}) begin
				s_next.off_ds = OFF_MIN;
			end else if (wv > {6'h00, OFF_TOP}) begin
				s_next.off_ds = OFF_TOP;
			end else begin
				s_next.off_ds = wv[9:0];
			end
		end

		// sequencer
		case (s_reg.phase)
			PH_OFF: begin
				// a pause freezes both prescaler and interval count, so the
				// remaining OFF time is kept rather than started again
				if (run_ok) begin
					s_next.pre_cnt = tick ? 17'h00000 : pre_inc;
					if (tick) begin
						if (off_done) begin
							s_next.phase  = PH_ON;
							s_next.ms_cnt = 16'h0000;
							s_next.idx    = fire_idx;
							s_next.sol    = fire_vec & en_vec;
						end else begin
							s_next.ms_cnt = ms_inc;
						end
					end else begin
						s_next.ms_cnt = s_reg.ms_cnt;
					end
				end else begin
					// paused: nothing counts and no output may start
					s_next.pre_cnt = s_reg.pre_cnt;
					s_next.ms_cnt  = s_reg.ms_cnt;
					s_next.sol     = '0;
				end
			end

			PH_ON: begin
				// a pulse in progress runs its full ON time even if the switch
				// opens; a cut pulse would leave the bag half cleaned
				s_next.pre_cnt = tick ? 17'h00000 : pre_inc;
				if (tick) begin
					if (on_done) begin
						s_next.phase  = PH_OFF;
						s_next.ms_cnt = 16'h0000;
						s_next.sol    = '0;
						// next output is kept, so a resume picks up after it
						s_next.idx    = idx_after;
					end else begin
						s_next.ms_cnt = ms_inc;
					end
				end else begin
					s_next.ms_cnt = s_reg.ms_cnt;
				end
			end

			default: begin
				s_next.phase = PH_OFF;
				s_next.sol   = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg.phase   <= PH_OFF;
			s_reg.idx     <= 4'h0;
			s_reg.ms_cnt  <= 16'h0000;
			s_reg.pre_cnt <= 17'h00000;
			s_reg.mode    <= 1'b0;
			s_reg.nout    <= NOUT_RST;
			s_reg.on_ms   <= ON_RST;
			s_reg.off_ds  <= OFF_RST;
			s_reg.sol     <= '0;
			s_reg.rsp     <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_o = s_reg.rsp;

	// each drive and its lamp come from one state bit, so a lamp can never
	// show a valve other than the one being pulsed
	generate
		for (g = 0; g < NOUT_MAX; g = g + 1) begin : g_out
			assign sol_o[g] = s_reg.sol[g];
			assign led_o[g] = s_reg.sol[g];
		end
	endgenerate
endmodule // pcs_seq

// file: tb/pcs_seq_asserts.sv
// port checker for the pulse sequencer
// assumes binding onto pcs_seq; TICK_CYCLES is handed on
`timescale 1ns/1ps
module pcs_seq_asserts
	import pcs_pkg::*;
#(
	parameter int TICK_CYCLES = 4
) (
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire pcs_wb_req_t         wb_i,
	input wire pcs_wb_rsp_t         wb_o,
	input wire logic                press_closed_i,
	input wire logic [NOUT_MAX-1:0] sol_o,
	input wire logic [NOUT_MAX-1:0] led_o
);
	localparam int OFF_C = 1500 * TICK_CYCLES - 1;
	logic [19:0] run_reg;
	logic [9:0]  last_reg;
	// run_reg: clocks since the drives last changed, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_reg <= '0;
			last_reg <= '0;
		end else begin
			run_reg <= $changed(sol_o) ? 20'h1 : run_reg + 20'(run_reg != '1);
			if (|sol_o) last_reg <= sol_o;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_i.cyc && wb_i.stb && !wb_o.ack;
	endsequence
	property p_led; led_o == sol_o; endproperty
	property p_one; $onehot0(sol_o); endproperty
	property p_hold; $rose(|sol_o) |=> $stable(sol_o)[*8]; endproperty
	property p_len; $fell(|sol_o) |-> run_reg >= 20 * TICK_CYCLES && run_reg <= 200 * TICK_CYCLES;
	endproperty
	property p_gap; $rose(|sol_o) |-> run_reg >= OFF_C; endproperty
	property p_ord; $rose(|sol_o) |-> sol_o == 10'h1 || sol_o == {last_reg[8:0], 1'b0};
	endproperty
	property p_ack; s_req |=> wb_o.ack; endproperty
	property p_ack1; wb_o.ack |=> !wb_o.ack; endproperty
	a_led: assert property (p_led) else $error("indicator differs");
	a_one: assert property (p_one) else $error("two drives on");
	a_hold: assert property (p_hold) else $error("pulse unsteady");
	a_len: assert property (p_len) else $error("pulse length out of range");
	a_gap: assert property (p_gap) else $error("off gap too short");
	a_ord: assert property (p_ord) else $error("output order");
	a_ack: assert property (p_ack) else $error("no ack");
	a_ack1: assert property (p_ack1) else $error("ack too long");
endmodule // pcs_seq_asserts
bind pcs_seq pcs_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) pcs_seq_asserts_inst (.clk_i(clk_i),
	.rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .press_closed_i(press_closed_i), .sol_o(sol_o),
	.led_o(led_o));

// file: tb/pcs_switch_model.sv
// differential pressure switch stand-in
// assumes a debounced dry contact; closed reads 1
`timescale 1ns/1ps
module pcs_switch_model (
	// command and contact
	input  wire logic close_i,
	output logic      closed_o
);
	assign closed_o = close_i;
endmodule // pcs_switch_model

// file: tb/tb.sv
// self-checking bench for the pulse sequencer
// assumes TICK_CYCLES of 4, one millisecond is four clocks
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb;
	import pcs_pkg::*;
	localparam int T = 4;
	logic        clk_i, rst_i, want, press;
	pcs_wb_req_t wb;
	pcs_wb_rsp_t wb_o;
	logic [9:0]  sol_o, led_o;
	logic [31:0] q, seed;
	int          n_mismatch, total_checks, on_ms, n;
	logic [7:0]  ofs[5] = '{CTRL_OFS, NOUT_OFS, ON_OFS, OFF_OFS, 8'h14};
	logic [9:0]  rv[5] = '{10'h0, 10'(NOUT_RST), 10'(ON_RST), OFF_RST, 10'h0};
	pcs_seq #(.TICK_CYCLES(T)) pcs_seq_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
		.wb_o(wb_o), .press_closed_i(press), .sol_o(sol_o), .led_o(led_o));
	pcs_switch_model pcs_switch_model_inst (.close_i(want), .closed_o(press));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb <= '{1'b1, 1'b1, w, a, 4'hf, d};
		do @(posedge clk_i); while (wb_o.ack !== 1'b1);
		q = wb_o.dat;
		wb <= '0;
		@(posedge clk_i);
	endtask
	// waits for the next pulse, checks which output and how long
	task automatic pulse(input logic [9:0] e);
		while (sol_o === 10'h0) @(posedge clk_i);
		`CHK(sol_o, e)
		`CHK(led_o, e)
		n = 0;
		do begin @(posedge clk_i); n++; end while (sol_o !== 10'h0);
		`CHK(n, on_ms * T)
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (90000) @(posedge clk_i);
		n_mismatch++;
		results();
	end
	initial begin
		rst_i = 1;
		want = 1;
		wb = '0;
		seed = xs(32'h508f);
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		foreach (ofs[i]) begin bus(0, ofs[i], 0); `CHK(q[9:0], rv[i]) end
		on_ms = 20 + int'(seed % 181);
		bus(1, ON_OFS, on_ms);
		bus(1, OFF_OFS, 15);
		bus(1, NOUT_OFS, 32'hf);
		bus(0, NOUT_OFS, 0);
		`CHK(q[3:0], NOUT_TOP)
		bus(1, NOUT_OFS, 2);
		pulse(10'h1);
		want <= 0;
		pulse(10'h2);
		pulse(10'h1);
		want <= 0;
		bus(1, CTRL_OFS, 1);
		bus(1, NOUT_OFS, 3);
		bus(0, STATUS_OFS, 0);
		`CHK(q[ST_PAUSE_BIT], 1'b1)
		`CHK(q[3:0], 4'h1)
		n = 0;
		repeat (8000) begin @(posedge clk_i); n += int'(sol_o !== 10'h0); end
		`CHK(n, 0)
		want <= 1;
		pulse(10'h2);
		pulse(10'h4);
		pulse(10'h1);
		results();
	end
endmodule // tb
